// ### verification/ltc_sensor_model.sv
// Behavioural model of the on-chip temperature sensor.
`timescale 1ns/1ps
module ltc_sensor_model (
    // Clock
    input logic clk,
    // Measurement request
    input logic measReq,
    input logic [7:0] measCode,
    // Sensor outputs
    output logic [7:0] temperatureCode,
    output logic temperatureValid
);
    initial
    begin
        temperatureCode = 8'h00;
        temperatureValid = 1'h0;
    end
    // The code is only meaningful with the strobe, so it toggles otherwise.
    always @(posedge clk)
    begin
        temperatureValid <= measReq;
        temperatureCode <= measReq ? measCode : ~temperatureCode;
    end
endmodule

// ### verification/ltc_top_asserts.sv
// Port-level property checker for the compensation block.
`timescale 1ns/1ps
module ltc_top_asserts (
    // Clock and reset
    input logic clk,
    input logic rst,
    // Register bus
    input logic [4:0] address,
    input logic read,
    input logic write,
    input logic [31:0] writedata,
    input logic [3:0] byteenable,
    input logic [31:0] readdata,
    input logic waitrequest,
    // Sensor and regulator
    input logic [7:0] temperatureCode,
    input logic temperatureValid,
    input logic [7:0] voltageCode,
    input logic chargePumpEnable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence reqWait;
        (read || write) && waitrequest;
    endsequence
    sequence reqAck;
        (read || write) && !waitrequest;
    endsequence
    sequence quiet3;
        (!temperatureValid && !write)[*3];
    endsequence
    AST_WAIT_ONE: assert property (reqWait |=> !waitrequest)
        else $error("request not answered after one wait cycle");
    AST_IDLE_NOWAIT: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest high without a request");
    AST_NEXT_WAITS: assert property (reqAck ##1 (read || write) |-> waitrequest)
        else $error("new request answered without a wait cycle");
    AST_RESET_OUT: assert property ($fell(rst) |-> voltageCode == 8'h00)
        else $error("voltage code not zero after reset");
    AST_PUMP_WRITE: assert property (
        reqAck ##0 (write && address == 5'h00 && byteenable[0])
        |-> ##2 chargePumpEnable == $past(writedata[1], 2))
        else $error("pump enable does not follow control write");
    AST_VPROG_DIRECT: assert property (
        write && !waitrequest && address == 5'h08 && byteenable[0] && !chargePumpEnable
        |-> ##2 voltageCode == $past(writedata[7:0], 2))
        else $error("uncompensated voltage code differs from programmed code");
    AST_UNMAPPED_READ: assert property (read && !waitrequest && address > 5'h14
        |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_QUIET_STABLE: assert property (quiet3 |=> $stable(voltageCode))
        else $error("voltage code moved without a cause");
    AST_PUMP_OFF_STABLE: assert property (
        (!chargePumpEnable && !write)[*3] |=> $stable(voltageCode))
        else $error("voltage code compensated with external supply");
endmodule

bind ltc_top ltc_top_asserts u_chk (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .temperatureCode(temperatureCode),
    .temperatureValid(temperatureValid), .voltageCode(voltageCode),
    .chargePumpEnable(chargePumpEnable));

// ### verification/tb_top.sv
// Self-checking bench for the compensation block.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0, measReq = 1'h0;
    logic [4:0] address = 5'h00;
    logic [31:0] writedata = 32'h0, readdata, rdVal, rdPair, lfsr = 32'h3AAD, r;
    logic [3:0] byteenable = 4'hF;
    logic [7:0] measCode = 8'h00, temperatureCode, voltageCode;
    logic temperatureValid, waitrequest, chargePumpEnable;
    logic [7:0] codes [10] = '{8'h00, 8'h20, 8'h21, 8'h40, 8'h41, 8'h60, 8'h61, 8'h7E,
        8'h7F, 8'hFF};
    int n_fail = 0, checked = 0, sl[4];
    always #20 clk = ~clk;
    ltc_sensor_model sensor (.clk(clk), .measReq(measReq), .measCode(measCode),
        .temperatureCode(temperatureCode), .temperatureValid(temperatureValid));
    ltc_top DUT (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .temperatureCode(temperatureCode),
        .temperatureValid(temperatureValid), .voltageCode(voltageCode),
        .chargePumpEnable(chargePumpEnable));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic int coef(int k);
        int t[8] = '{0, -1, -2, -4, -10, 1, 2, 4};
        return t[k];
    endfunction
    function automatic int expOff(int c);
        int a, b, m, d, s;
        a = coef(sl[0]);
        b = coef(sl[1]);
        m = coef(sl[2]);
        d = coef(sl[3]);
        if (c > 127) c = 127;
        if (c <= 32) s = (c - 32) * a - 32 * b;
        else if (c <= 64) s = (c - 64) * b;
        else if (c <= 96) s = (c - 64) * m;
        else if (c <= 126) s = (c - 96) * d + 32 * m;
        else s = 31 * d + 32 * m;
        return (s + 4) >>> 3;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        read <= !we;
        write <= we;
        address <= a;
        writedata <= d;
        do
        begin
            @(posedge clk);
        end
        while (waitrequest !== 1'h0);
        rdVal = readdata;
        read <= 1'h0;
        write <= 1'h0;
    endtask
    // Two reads back to back: read stays high and only the address moves on.
    task automatic read_pair(input logic [4:0] a0, input logic [4:0] a1,
        output logic [31:0] d0, output logic [31:0] d1);
        @(posedge clk);
        read <= 1'h1;
        address <= a0;
        do
        begin
            @(posedge clk);
        end
        while (waitrequest !== 1'h0);
        d0 = readdata;
        address <= a1;
        do
        begin
            @(posedge clk);
        end
        while (waitrequest !== 1'h0);
        d1 = readdata;
        read <= 1'h0;
    endtask
    task automatic run(input logic [1:0] ctrl, input logic [11:0] slo, input logic [7:0] vp,
        input logic [7:0] code);
        int v, o;
        for (int i = 0; i < 4; i++) sl[i] = slo[3 * i +: 3];
        bus(1'h1, 5'h00, {30'h0, ctrl});
        bus(1'h1, 5'h04, {20'h0, slo});
        bus(1'h1, 5'h08, {24'h0, vp});
        @(posedge clk);
        measReq <= 1'h1;
        measCode <= code;
        @(posedge clk);
        measReq <= 1'h0;
        repeat (5) @(posedge clk);
        v = vp;
        o = expOff(code);
        if (ctrl == 2'h3) v = v + o;
        if (v < 0) v = 0;
        if (v > 255) v = 255;
        bus(1'h0, 5'h0C, 32'h0);
        check("temp", rdVal, {24'h0, code});
        bus(1'h0, 5'h10, 32'h0);
        check("offset", rdVal, {24'h0, 8'(o)});
        bus(1'h0, 5'h14, 32'h0);
        check("vout", rdVal, {24'h0, 8'(v)});
        check("voltageCode", {24'h0, voltageCode}, {24'h0, 8'(v)});
        check("pump", {31'h0, chargePumpEnable}, {31'h0, ctrl[1]});
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        check("voltageCode", {24'h0, voltageCode}, 32'h0);
        read_pair(5'h08, 5'h0C, rdVal, rdPair);
        check("vprog", rdVal, 32'h0);
        check("temp", rdPair, 32'h40);
        bus(1'h0, 5'h10, 32'h0);
        check("offset", rdVal, 32'h0);
        bus(1'h0, 5'h04, 32'h0);
        check("slope", rdVal, 32'h0);
        bus(1'h0, 5'h18, 32'h0);
        check("unmapped", rdVal, 32'h0);
        $display("test reset done");
        byteenable <= 4'h1;
        bus(1'h1, 5'h04, 32'hFFFF_FFFF);
        byteenable <= 4'h0;
        bus(1'h1, 5'h00, 32'h0000_0003);
        byteenable <= 4'hF;
        bus(1'h0, 5'h04, 32'h0);
        check("slope lanes", rdVal, 32'h0000_00FF);
        bus(1'h0, 5'h00, 32'h0);
        check("ctrl lanes", rdVal, 32'h0);
        $display("test lanes done");
        for (int i = 0; i < 10; i++) run(2'h3, 12'hF19, 8'h80, codes[i]);
        $display("test regions done");
        for (int k = 0; k < 8; k++) run(2'h3, {4{3'(k)}}, 8'h80, 8'h00);
        $display("test slopes done");
        run(2'h3, 12'hFFF, 8'hF0, 8'h7F);
        run(2'h3, 12'hFFF, 8'h10, 8'h00);
        $display("test clamp done");
        repeat (40)
        begin
            r = rnd();
            run(r[1:0], r[13:2], r[21:14], r[29:22]);
        end
        $display("test random done");
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        check("voltageCode", {24'h0, voltageCode}, 32'h0);
        read_pair(5'h08, 5'h0C, rdVal, rdPair);
        check("vprog", rdVal, 32'h0);
        check("temp", rdPair, 32'h40);
        $display("test reset again done");
        stop_test();
    end
    initial
    begin
        repeat (30000) @(posedge clk);
        n_fail++;
        stop_test();
    end
endmodule

// ### verilog/ltc_params.svh
// Register offsets, field positions, reset values and region bounds of the compensation block.
`ifndef LTC_PARAMS_SVH
`define LTC_PARAMS_SVH

// Register byte offsets.
`define LTC_ADDR_CTRL 5'h00
`define LTC_ADDR_SLOPE 5'h04
`define LTC_ADDR_VPROG 5'h08
`define LTC_ADDR_TEMP 5'h0C
`define LTC_ADDR_OFFSET 5'h10
`define LTC_ADDR_VOUT 5'h14

// Control register fields.
`define LTC_CTRL_ENABLE_BIT 0
`define LTC_CTRL_PUMP_BIT 1

// Slope register fields, three bits per region.
`define LTC_SLOPE_A_LSB 0
`define LTC_SLOPE_B_LSB 3
`define LTC_SLOPE_C_LSB 6
`define LTC_SLOPE_D_LSB 9

// Reset values.
`define LTC_VPROG_RESET 8'h00
`define LTC_TEMP_RESET 8'h40
`define LTC_SLOPE_RESET 3'h0

// Temperature code bounds and bases of the four regions.
`define LTC_REGION_A_TOP 8'h20
`define LTC_REGION_B_TOP 8'h40
`define LTC_REGION_C_TOP 8'h60
`define LTC_REGION_D_TOP 8'h7E
`define LTC_CODE_MAX 8'h7F
`define LTC_BASE_A 8'h20
`define LTC_BASE_BC 8'h40
`define LTC_BASE_D 8'h60
`define LTC_SPAN 8'h20
`define LTC_LAST_STEPS 8'h1F

// Fixed point: coefficients in eighths, output in steps of 30 mV.
`define LTC_FRAC_BITS 3
`define LTC_ROUND_HALF 13'sh0004
`define LTC_STEP_MV 30
`define LTC_CODE_TOP 10'h0FF

`endif

// ### verilog/ltc_pkg.sv
// Types shared by the compensation block.
package ltc_pkg;

    typedef struct packed {
        logic [2:0] slopeSelectRegionD;
        logic [2:0] slopeSelectRegionC;
        logic [2:0] slopeSelectRegionB;
        logic [2:0] slopeSelectRegionA;
    } ltc_slopes_s;

    typedef enum logic [1:0] {
        LTC_BUS_IDLE = 2'b01,
        LTC_BUS_ACK = 2'b10
    } ltc_bus_state_e;

    typedef logic signed [11:0] ltc_eighths_t;

endpackage

// ### verilog/ltc_sat_add.sv
// Adds a signed offset to an unsigned code and clamps to the 8-bit range.
`timescale 1ns/1ps
`include "ltc_params.svh"

module ltc_sat_add
    import ltc_pkg::*;
(
    // Operands
    input logic [7:0] baseCode,
    input logic signed [7:0] offsetCode,
    // Result
    output logic [7:0] sumCode
);

    logic signed [9:0] wide;

    assign wide = $signed({2'b00, baseCode}) + $signed({{2{offsetCode[7]}}, offsetCode});

    always_comb
    begin
        if (wide < 10'sh000)
        begin
            sumCode = 8'h00;
        end
        else if (wide > $signed(`LTC_CODE_TOP))
        begin
            sumCode = 8'hFF;
        end
        else
        begin
            sumCode = wide[7:0];
        end
    end

endmodule

// ### verilog/ltc_slope_mult.sv
// Multiplies a signed step count by one region coefficient, result in eighths.
`timescale 1ns/1ps
`include "ltc_params.svh"

module ltc_slope_mult
    import ltc_pkg::*;
(
    // Operands
    input logic signed [7:0] steps,
    input logic [2:0] slopeSelect,
    // Result
    output ltc_eighths_t product
);

    logic signed [4:0] coef;
    logic signed [12:0] full;

    always_comb
    begin
        case (slopeSelect)
            3'h0: coef = 5'sh00;
            3'h1: coef = -5'sh01;
            3'h2: coef = -5'sh02;
            3'h3: coef = -5'sh04;
            3'h4: coef = -5'sh0A;
            3'h5: coef = 5'sh01;
            3'h6: coef = 5'sh02;
            3'h7: coef = 5'sh04;
            default: coef = 5'sh00;
        endcase
    end

    assign full = steps * coef;
    assign product = full[11:0];

endmodule

// ### verilog/ltc_top.sv
// Temperature compensation of the LCD drive voltage code, with its register slave.
//
// Summary of operation
// - Offset is added to the voltage code only while compensation is enabled.
// - Temperature span splits into four regions, each with its own slope select.
// - Slope codes map to 0, -1/8, -1/4, -1/2, -5/4, +1/8, +1/4, +1/2.
// - Offset is counted in whole 30 mV steps, not a continuous correction.
// - Reset leaves voltage code zero and temperature code 40h, so offset zero.
// - Final code is programmed code plus two's complement offset, zero at 40h.
// - Sum is an unsigned byte that saturates at either end instead of wrapping.
// - Code 0h gives -32 times region A plus -32 times region B coefficient.
// - Codes 0h-20h give (code-32) times A minus 32 times B.
// - Codes 21h-40h give (code-64) times B.
// - Codes 41h-60h give (code-64) times C.
// - Codes 61h-7Eh give (code-96) times D plus 32 times C.
// - Code 7Fh and above holds 31 times D plus 32 times C.
// - Input code means 0.9375 degrees per count, minus 40 degrees.
// - With the charge pump off the supply is external and gets no offset.
`timescale 1ns/1ps
`include "ltc_params.svh"

module ltc_top
    import ltc_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic rst,
    // Avalon-MM slave
    input logic [4:0] address,
    input logic read,
    input logic write,
    input logic [31:0] writedata,
    input logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Temperature measurement
    input logic [7:0] temperatureCode,
    input logic temperatureValid,
    // Charge pump regulator
    output logic [7:0] voltageCode,
    output logic chargePumpEnable
);

    // Bus handshake state.
    ltc_bus_state_e busState_reg;
    ltc_bus_state_e busState_next;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;

    // Software-visible configuration.
    logic tempCompEnable_reg;
    logic tempCompEnable_next;
    logic pumpEnable_reg;
    logic pumpEnable_next;
    ltc_slopes_s slopes_reg;
    ltc_slopes_s slopes_next;
    logic [7:0] lcdVoltageProgram_reg;
    logic [7:0] lcdVoltageProgram_next;

    // Datapath state.
    logic [7:0] tempCode_reg;
    logic [7:0] tempCode_next;
    logic [7:0] offsetCode_reg;
    logic [7:0] offsetCode_next;
    logic [7:0] voltageCode_reg;
    logic [7:0] voltageCode_next;

    // Datapath intermediates.
    logic [7:0] codeClamped;
    logic signed [7:0] stepsFirst;
    logic signed [7:0] stepsSecond;
    logic [2:0] selectFirst;
    logic [2:0] selectSecond;
    ltc_eighths_t termFirst;
    ltc_eighths_t termSecond;
    logic signed [12:0] sumEighths;
    logic signed [12:0] roundedEighths;
    logic signed [7:0] appliedOffset;
    logic [7:0] sumCode;
    logic writeCommit;
    logic [31:0] byteMask;

    // The request is answered one cycle after it is first seen.
    assign waitrequest = (read | write) & (busState_reg == LTC_BUS_IDLE);
    assign writeCommit = write & (busState_reg == LTC_BUS_ACK);
    assign byteMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                       {8{byteenable[1]}}, {8{byteenable[0]}}};

    always_comb
    begin
        busState_next = busState_reg;
        readdata_next = readdata_reg;
        case (busState_reg)
            LTC_BUS_IDLE:
            begin
                if (read | write)
                begin
                    busState_next = LTC_BUS_ACK;
                end
                if (read)
                begin
                    case (address)
                        `LTC_ADDR_CTRL:
                            readdata_next = {30'h0, pumpEnable_reg, tempCompEnable_reg};
                        `LTC_ADDR_SLOPE:
                            readdata_next = {20'h0, slopes_reg};
                        `LTC_ADDR_VPROG:
                            readdata_next = {24'h0, lcdVoltageProgram_reg};
                        `LTC_ADDR_TEMP:
                            readdata_next = {24'h0, tempCode_reg};
                        `LTC_ADDR_OFFSET:
                            readdata_next = {24'h0, offsetCode_reg};
                        `LTC_ADDR_VOUT:
                            readdata_next = {24'h0, voltageCode_reg};
                        default:
                            readdata_next = 32'h0000_0000;
                    endcase
                end
            end
            LTC_BUS_ACK:
            begin
                busState_next = LTC_BUS_IDLE;
            end
            default:
            begin
                busState_next = LTC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busState_reg <= LTC_BUS_IDLE;
            readdata_reg <= 32'h0000_0000;
        end
        else
        begin
            busState_reg <= busState_next;
            readdata_reg <= readdata_next;
        end
    end

    assign readdata = readdata_reg;

    // Register writes take effect at the edge that completes the transfer.
    always_comb
    begin
        tempCompEnable_next = tempCompEnable_reg;
        pumpEnable_next = pumpEnable_reg;
        slopes_next = slopes_reg;
        lcdVoltageProgram_next = lcdVoltageProgram_reg;
        if (writeCommit)
        begin
            case (address)
                `LTC_ADDR_CTRL:
                begin
                    if (byteenable[0])
                    begin
                        tempCompEnable_next = writedata[`LTC_CTRL_ENABLE_BIT];
                        pumpEnable_next = writedata[`LTC_CTRL_PUMP_BIT];
                    end
                end
                `LTC_ADDR_SLOPE:
                begin
                    slopes_next = (writedata[11:0] & byteMask[11:0])
                                  | (slopes_reg & ~byteMask[11:0]);
                end
                `LTC_ADDR_VPROG:
                begin
                    if (byteenable[0])
                    begin
                        lcdVoltageProgram_next = writedata[7:0];
                    end
                end
                default:
                begin
                    lcdVoltageProgram_next = lcdVoltageProgram_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tempCompEnable_reg <= 1'b0;
            pumpEnable_reg <= 1'b0;
            slopes_reg <= {4{`LTC_SLOPE_RESET}};
            lcdVoltageProgram_reg <= `LTC_VPROG_RESET;
        end
        else
        begin
            tempCompEnable_reg <= tempCompEnable_next;
            pumpEnable_reg <= pumpEnable_next;
            slopes_reg <= slopes_next;
            lcdVoltageProgram_reg <= lcdVoltageProgram_next;
        end
    end

    assign chargePumpEnable = pumpEnable_reg;

    // Codes above the top of the scale are treated as the top code.
    // code beyond 80 degrees
    assign codeClamped = (tempCode_reg > `LTC_CODE_MAX) ? `LTC_CODE_MAX : tempCode_reg;

    // Each region is expressed as stepsFirst * coefFirst + stepsSecond * coefSecond.
    always_comb
    begin
        if (codeClamped <= `LTC_REGION_A_TOP)
        begin
            stepsFirst = $signed(codeClamped - `LTC_BASE_A);
            selectFirst = slopes_reg.slopeSelectRegionA;
            stepsSecond = -$signed(`LTC_SPAN);
            selectSecond = slopes_reg.slopeSelectRegionB;
        end
        else if (codeClamped <= `LTC_REGION_B_TOP)
        begin
            stepsFirst = $signed(codeClamped - `LTC_BASE_BC);
            selectFirst = slopes_reg.slopeSelectRegionB;
            stepsSecond = 8'sh00;
            selectSecond = slopes_reg.slopeSelectRegionB;
        end
        else if (codeClamped <= `LTC_REGION_C_TOP)
        begin
            stepsFirst = $signed(codeClamped - `LTC_BASE_BC);
            selectFirst = slopes_reg.slopeSelectRegionC;
            stepsSecond = 8'sh00;
            selectSecond = slopes_reg.slopeSelectRegionC;
        end
        else if (codeClamped <= `LTC_REGION_D_TOP)
        begin
            stepsFirst = $signed(codeClamped - `LTC_BASE_D);
            selectFirst = slopes_reg.slopeSelectRegionD;
            stepsSecond = $signed(`LTC_SPAN);
            selectSecond = slopes_reg.slopeSelectRegionC;
        end
        else
        begin
            stepsFirst = $signed(`LTC_LAST_STEPS);
            selectFirst = slopes_reg.slopeSelectRegionD;
            stepsSecond = $signed(`LTC_SPAN);
            selectSecond = slopes_reg.slopeSelectRegionC;
        end
    end

    ltc_slope_mult multFirst (
        .steps(stepsFirst),
        .slopeSelect(selectFirst),
        .product(termFirst)
    );

    ltc_slope_mult multSecond (
        .steps(stepsSecond),
        .slopeSelect(selectSecond),
        .product(termSecond)
    );

    assign sumEighths = 13'(termFirst) + 13'(termSecond);
    assign roundedEighths = (sumEighths + `LTC_ROUND_HALF) >>> `LTC_FRAC_BITS;

    assign appliedOffset = (tempCompEnable_reg & pumpEnable_reg)
                           ? roundedEighths[7:0] : 8'sh00;

    ltc_sat_add satAdd (
        .baseCode(lcdVoltageProgram_reg),
        .offsetCode(appliedOffset),
        .sumCode(sumCode)
    );

    always_comb
    begin
        tempCode_next = tempCode_reg;
        if (temperatureValid)
        begin
            tempCode_next = temperatureCode;
        end
        offsetCode_next = roundedEighths[7:0];
        voltageCode_next = sumCode;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tempCode_reg <= `LTC_TEMP_RESET;
            offsetCode_reg <= 8'h00;
            voltageCode_reg <= `LTC_VPROG_RESET;
        end
        else
        begin
            tempCode_reg <= tempCode_next;
            offsetCode_reg <= offsetCode_next;
            voltageCode_reg <= voltageCode_next;
        end
    end

    assign voltageCode = voltageCode_reg;

endmodule
